// ### zone_plate_pattern_generator.sv
`timescale 1ns/10ps
`default_nettype none
`include "zp_consts.svh"

module zone_plate_pattern_generator import zp_pkg::*; #(
  parameter bit DEFAULT_RGB = 1'b0
) (
  // Clock and resets.
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clear_i,
  // Parameter port.
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Raster timing from the video timing generator.
  input wire logic frame_start_i,
  input wire logic line_start_i,
  input wire logic active_i,
  // Pixel output: first, second and third colour component.
  output logic [9:0] comp0_o,
  output logic [9:0] comp1_o,
  output logic [9:0] comp2_o,
  output logic valid_o
);

  logic [`ZP_CTRL_W-1:0] ctrl;
  logic [10:0] pattern_amplitude;
  coef_t coef [`ZP_NUM_COEF];
  coef_t shadow [`ZP_NUM_COEF];
  coef_t time_phase;
  coef_t time_sweep;
  coef_t time_hfreq;
  coef_t time_vfreq;
  logic [31:0] time_count;
  coef_t line_phase;
  coef_t line_vfreq;
  coef_t line_hfreq;
  coef_t pix_phase;
  coef_t pix_freq;
  logic [9:0] unit_level;
  logic unit_valid;
  logic [31:0] level_prod;
  logic [10:0] luma_sum;
  logic [10:0] chroma_sum;
  logic [9:0] next_luma;
  logic [9:0] next_chroma;
  shape_e shape_sel;
  logic [31:0] next_rdata;

  // Shape field decode; the unused code falls back to sine inside the shaper.
  assign shape_sel = shape_e'(ctrl[`ZP_CTRL_SHAPE_HI:`ZP_CTRL_SHAPE_LO]);

  // Control register: component switches, time reset, shape and structure.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl <= {DEFAULT_RGB, 2'b00, 1'b0, DEFAULT_RGB, DEFAULT_RGB, 1'b1};
    end else if (wr_i && addr_i == `ZP_REG_CTRL) begin
      ctrl <= wdata_i[`ZP_CTRL_W-1:0];
    end
  end

  // Amplitude register; writes above the ceiling saturate at it.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pattern_amplitude <= `ZP_AMP_RESET;
    end else if (wr_i && addr_i == `ZP_REG_AMP) begin
      if (wdata_i > 32'(`ZP_AMP_MAX)) begin
        pattern_amplitude <= `ZP_AMP_MAX;
      end else begin
        pattern_amplitude <= wdata_i[10:0];
      end
    end
  end

  // Coefficient registers, written by software at any time.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < `ZP_NUM_COEF; i++) begin
        coef[i] <= '0;
      end
    end else begin
      for (int i = 0; i < `ZP_NUM_COEF; i++) begin
        if (wr_i && addr_i == 8'(`ZP_REG_COEF_BASE + 4 * i)) begin
          coef[i] <= wdata_i;
        end
      end
    end
  end

  // Read mux; unmapped addresses read as zero.
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (addr_i == `ZP_REG_CTRL) begin
      next_rdata = 32'(ctrl);
    end else if (addr_i == `ZP_REG_AMP) begin
      next_rdata = 32'(pattern_amplitude);
    end else if (addr_i == `ZP_REG_TIME) begin
      next_rdata = time_count;
    end
    for (int i = 0; i < `ZP_NUM_COEF; i++) begin
      if (addr_i == 8'(`ZP_REG_COEF_BASE + 4 * i)) begin
        next_rdata = coef[i];
      end
    end
  end

  // Read data stands in the cycle after the strobe only.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // Working copy of the coefficients, refreshed only at a frame boundary.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < `ZP_NUM_COEF; i++) begin
        shadow[i] <= '0;
      end
    end else if (frame_start_i) begin
      for (int i = 0; i < `ZP_NUM_COEF; i++) begin
        shadow[i] <= coef[i];
      end
    end
  end

  // Time coordinate, stepped once per frame; all sums wrap modulo one cycle,
  // which gives the phase flip and the return through DC at the format limit.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      time_phase <= '0;
      time_sweep <= '0;
      time_hfreq <= '0;
      time_vfreq <= '0;
      time_count <= 32'h0000_0000;
    end else if (clear_i || (frame_start_i && ctrl[`ZP_CTRL_TRES])) begin
      time_phase <= '0;
      time_sweep <= '0;
      time_hfreq <= '0;
      time_vfreq <= '0;
      time_count <= 32'h0000_0000;
    end else if (frame_start_i) begin
      time_phase <= time_phase + coef[`ZP_K_T] + time_sweep;
      time_sweep <= time_sweep + coef[`ZP_K_T2];
      time_hfreq <= time_hfreq + coef[`ZP_K_XT];
      time_vfreq <= time_vfreq + coef[`ZP_K_YT];
      time_count <= time_count + 32'h0000_0001;
    end
  end

  // Per-line state: start phase, vertical frequency and line horizontal frequency.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_phase <= '0;
      line_vfreq <= '0;
      line_hfreq <= '0;
    end else if (clear_i) begin
      line_phase <= '0;
      line_vfreq <= '0;
      line_hfreq <= '0;
    end else if (frame_start_i) begin
      line_phase <= coef[`ZP_K_PHASE] + time_phase;
      line_vfreq <= coef[`ZP_K_Y] + time_vfreq;
      line_hfreq <= coef[`ZP_K_X] + time_hfreq;
    end else if (line_start_i) begin
      line_phase <= line_phase + line_vfreq;
      line_vfreq <= line_vfreq + shadow[`ZP_K_Y2];
      line_hfreq <= line_hfreq + shadow[`ZP_K_XY];
    end
  end

  // Per-sample state: phase steps by the horizontal frequency, which the sweep raises.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pix_phase <= '0;
      pix_freq <= '0;
    end else if (clear_i) begin
      pix_phase <= '0;
      pix_freq <= '0;
    end else if (line_start_i) begin
      pix_phase <= line_phase;
      pix_freq <= line_hfreq;
    end else if (active_i) begin
      pix_phase <= pix_phase + pix_freq;
      pix_freq <= pix_freq + shadow[`ZP_K_X2];
    end
  end

  // Phase to unit level through the selected shape.
  zp_wave_shaper u_shaper (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .phase_i(pix_phase[31:20]),
    .shape_i(shape_sel),
    .valid_i(active_i),
    .level_o(unit_level),
    .valid_o(unit_valid)
  );

  // Amplitude scaling into video codes, saturated at the legal maximum.
  always_comb begin
    level_prod = (32'(unit_level) * 32'(pattern_amplitude) * `ZP_LEVEL_MUL) >> `ZP_LEVEL_SHIFT;
    luma_sum = 11'(`ZP_BLACK) + level_prod[10:0];
    chroma_sum = 11'(`ZP_CHROMA_LOW) + level_prod[10:0];
    next_luma = (luma_sum > 11'(`ZP_CODE_MAX)) ? `ZP_CODE_MAX : luma_sum[9:0];
    next_chroma = (chroma_sum > 11'(`ZP_CODE_MAX)) ? `ZP_CODE_MAX : chroma_sum[9:0];
  end

  // Output registers; a disabled component rests at black or zero chroma.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      comp0_o <= `ZP_BLACK;
      comp1_o <= `ZP_ZERO_CHROMA;
      comp2_o <= `ZP_ZERO_CHROMA;
      valid_o <= 1'b0;
    end else begin
      valid_o <= unit_valid;
      comp0_o <= ctrl[`ZP_CTRL_EN0] ? next_luma : `ZP_BLACK;
      if (ctrl[`ZP_CTRL_RGB]) begin
        comp1_o <= ctrl[`ZP_CTRL_EN1] ? next_luma : `ZP_BLACK;
        comp2_o <= ctrl[`ZP_CTRL_EN2] ? next_luma : `ZP_BLACK;
      end else begin
        comp1_o <= ctrl[`ZP_CTRL_EN1] ? next_chroma : `ZP_ZERO_CHROMA;
        comp2_o <= ctrl[`ZP_CTRL_EN2] ? next_chroma : `ZP_ZERO_CHROMA;
      end
    end
  end

  chk_amp_ceiling_held: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_i && addr_i == `ZP_REG_AMP && wdata_i > 32'h0000_063c
    |=> pattern_amplitude == 11'h63c)
    else $error("amplitude not saturated at ceiling");

  chk_time_reset_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    frame_start_i && ctrl[`ZP_CTRL_TRES] |=> time_count == 32'h0 && time_phase == 32'sh0)
    else $error("time coordinate not cleared by time reset");

  chk_time_advance_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !clear_i && !ctrl[`ZP_CTRL_TRES] ##0 !frame_start_i [*2]
    |-> $stable(time_count) && $stable(time_phase))
    else $error("time coordinate moved between frames");

  chk_shadow_frame_only: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !frame_start_i |=> shadow[`ZP_K_X2] == $past(shadow[`ZP_K_X2]))
    else $error("sweep coefficient changed inside a frame");

  chk_horiz_sweep_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    active_i && !line_start_i && !clear_i
    |=> pix_freq == $past(pix_freq) + $past(shadow[`ZP_K_X2]))
    else $error("sample frequency not stepped by sweep");

  chk_vert_sweep_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    line_start_i && !frame_start_i && !clear_i
    |=> line_vfreq == $past(line_vfreq) + $past(shadow[`ZP_K_Y2]))
    else $error("vertical frequency not stepped per line");

  chk_line_start_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    line_start_i && !clear_i |=> pix_freq == $past(line_hfreq) && pix_phase == $past(line_phase))
    else $error("line start did not load line state");

  chk_output_latency: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    active_i |-> ##2 valid_o)
    else $error("output valid not two cycles after active");

  chk_disabled_chroma: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !ctrl[`ZP_CTRL_RGB] && !ctrl[`ZP_CTRL_EN1] |=> comp1_o == 10'h200)
    else $error("disabled second component not at zero chroma");

  chk_read_amp: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rd_i && addr_i == `ZP_REG_AMP |=> rdata_o == 32'($past(pattern_amplitude)))
    else $error("amplitude readback wrong");

  // Time terms step once per frame from the live coefficients, unless cleared.
  chk_time_phase_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    frame_start_i && !clear_i && !ctrl[`ZP_CTRL_TRES]
    |=> time_phase == $past(time_phase) + $past(coef[`ZP_K_T]) + $past(time_sweep))
    else $error("temporal phase not stepped at frame start");

  chk_time_sweep_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    frame_start_i && !clear_i && !ctrl[`ZP_CTRL_TRES]
    |=> time_sweep == $past(time_sweep) + $past(coef[`ZP_K_T2]))
    else $error("temporal sweep not stepped at frame start");

  chk_time_hfreq_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    frame_start_i && !clear_i && !ctrl[`ZP_CTRL_TRES]
    |=> time_hfreq == $past(time_hfreq) + $past(coef[`ZP_K_XT]))
    else $error("timed horizontal frequency not stepped");

  chk_time_vfreq_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    frame_start_i && !clear_i && !ctrl[`ZP_CTRL_TRES]
    |=> time_vfreq == $past(time_vfreq) + $past(coef[`ZP_K_YT]))
    else $error("timed vertical frequency not stepped");

  // Each frame starts its line state from the live coefficients and the time terms.
  chk_frame_phase_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    frame_start_i && !clear_i
    |=> line_phase == $past(coef[`ZP_K_PHASE]) + $past(time_phase))
    else $error("frame start phase not loaded");

  chk_frame_vfreq_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    frame_start_i && !clear_i
    |=> line_vfreq == $past(coef[`ZP_K_Y]) + $past(time_vfreq))
    else $error("frame start vertical frequency not loaded");

  // The synchronous clear empties every phase accumulator at once.
  chk_clear_zeroes_all: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    clear_i |=> pix_phase == 32'sh0 && line_phase == 32'sh0 && time_phase == 32'sh0)
    else $error("clear left a phase accumulator set");

  // Output codes: disabled components rest at their level, nothing passes the legal top.
  chk_disabled_luma_black: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !ctrl[`ZP_CTRL_EN0] |=> comp0_o == 10'h040)
    else $error("disabled first component not at black");

  chk_rgb_disabled_black: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ctrl[`ZP_CTRL_RGB] && !ctrl[`ZP_CTRL_EN2] |=> comp2_o == 10'h040)
    else $error("disabled third component not at black");

  chk_code_ceiling_kept: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    comp0_o < 10'h3fc && comp1_o < 10'h3fc && comp2_o < 10'h3fc)
    else $error("output code above the legal maximum");

endmodule : zone_plate_pattern_generator

`default_nettype wire

// ### zp_consts.svh
`ifndef ZP_CONSTS_SVH
`define ZP_CONSTS_SVH

// Register byte addresses on the parameter port.
`define ZP_REG_CTRL 8'h00
`define ZP_REG_AMP 8'h04
`define ZP_REG_COEF_BASE 8'h08
`define ZP_REG_TIME 8'h30

// Control register field positions.
`define ZP_CTRL_EN0 0
`define ZP_CTRL_EN1 1
`define ZP_CTRL_EN2 2
`define ZP_CTRL_TRES 3
`define ZP_CTRL_SHAPE_LO 4
`define ZP_CTRL_SHAPE_HI 5
`define ZP_CTRL_RGB 6
`define ZP_CTRL_W 7

// Amplitude in half-millivolt steps: 798.0 mV ceiling, 700 mV after reset.
`define ZP_AMP_MAX 11'h63c
`define ZP_AMP_RESET 11'h578

// Coefficient slots, one word each from the coefficient base upward.
`define ZP_NUM_COEF 10
`define ZP_K_PHASE 0
`define ZP_K_X 1
`define ZP_K_Y 2
`define ZP_K_T 3
`define ZP_K_XT 4
`define ZP_K_YT 5
`define ZP_K_XY 6
`define ZP_K_X2 7
`define ZP_K_Y2 8
`define ZP_K_T2 9

// Output coding: level = unit wave times amplitude times multiplier, shifted down.
`define ZP_LEVEL_MUL 32'h0000_0502
`define ZP_LEVEL_SHIFT 21
`define ZP_BLACK 10'h040
`define ZP_ZERO_CHROMA 10'h200
`define ZP_CHROMA_LOW 10'h04a
`define ZP_CODE_MAX 10'h3fb

// Sine refinement weight on the parabola, in 1/1024 units.
`define ZP_SINE_REFINE 11'h0e6

`endif

// ### zp_pkg.sv
package zp_pkg;

  // Shape applied to the phase before amplitude scaling.
  typedef enum logic [1:0] {SHAPE_SINE, SHAPE_TRIANGLE, SHAPE_SQUARE} shape_e;

  // Phase and frequency words: cycles as a 32-bit fraction, wrapping mod one cycle.
  typedef logic signed [31:0] coef_t;

endpackage : zp_pkg

// ### zp_wave_shaper.sv
`timescale 1ns/10ps
`default_nettype none
`include "zp_consts.svh"

module zp_wave_shaper import zp_pkg::*; (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Phase in, top twelve bits of the cycle fraction.
  input wire logic [11:0] phase_i,
  input wire shape_e shape_i,
  input wire logic valid_i,
  // Unipolar level, 1 is the negative peak and 1023 the positive peak.
  output logic [9:0] level_o,
  output logic valid_o
);

  logic [9:0] half_pos;
  logic [20:0] para;
  logic [10:0] y0;
  logic [21:0] curv;
  logic [21:0] adj;
  logic [10:0] ys;
  logic [9:0] mag;
  logic [10:0] next_level;

  // Parabola per half cycle with a curvature correction gives a close sine.
  always_comb begin
    half_pos = phase_i[10:1];
    para = 21'(half_pos) * (21'h000400 - 21'(half_pos));
    y0 = para[18:8];
    curv = (22'(y0) * (22'h000400 - 22'(y0))) >> 10;
    adj = (curv * 22'(`ZP_SINE_REFINE)) >> 10;
    ys = y0 - adj[10:0];
    unique case (shape_i)
      SHAPE_SINE: mag = ys[10:1];
      SHAPE_TRIANGLE: mag = half_pos[9] ? 10'(10'h3ff - half_pos) : half_pos;
      SHAPE_SQUARE: mag = 10'h1ff;
      default: mag = ys[10:1];
    endcase
    if (mag > 10'h1ff) begin
      mag = 10'h1ff;
    end
    next_level = phase_i[11] ? 11'(11'h200 - 11'(mag)) : 11'(11'h200 + 11'(mag));
  end

  // Registered level, so the main pipeline sees a fixed one-cycle latency.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_o <= 10'h000;
      valid_o <= 1'b0;
    end else begin
      level_o <= next_level[10] ? 10'h3ff : next_level[9:0];
      valid_o <= valid_i;
    end
  end

  chk_square_peak_level: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    valid_i && shape_i == SHAPE_SQUARE && !phase_i[11] |=> level_o == 10'h3ff)
    else $error("square wave positive half not at peak");

endmodule : zp_wave_shaper

`default_nettype wire

// ### zp_pixel_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module zp_pixel_monitor (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Raster strobe and the generator's pixel stream.
  input wire logic active_i,
  input wire logic valid_i,
  input wire logic [9:0] comp0_i,
  input wire logic [9:0] comp1_i,
  input wire logic [9:0] comp2_i
);
  logic [29:0] cap[$];
  logic [1:0] act_pipe = 2'b00;
  int late_count = 0;

  // Records each delivered sample and counts strobes that are not two cycles behind the raster.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      act_pipe <= 2'b00;
    end else begin
      act_pipe <= {act_pipe[0], active_i};
      if (valid_i !== act_pipe[1]) late_count++;
      if (valid_i === 1'b1) cap.push_back({comp2_i, comp1_i, comp0_i});
    end
  end
endmodule : zp_pixel_monitor
`default_nettype wire

// ### tb_zone_plate_pattern_generator.sv
`timescale 1ns/10ps
`default_nettype none
`include "zp_consts.svh"

module tb_zone_plate_pattern_generator;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic clear_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic frame_start_i = 1'b0;
  logic line_start_i = 1'b0;
  logic active_i = 1'b0;
  logic [31:0] rdata_o;
  logic [9:0] comp0_o;
  logic [9:0] comp1_o;
  logic [9:0] comp2_o;
  logic valid_o;
  logic [31:0] rv;
  int err_count = 0;
  int total_checks = 0;

  // The sample clock runs at 125 MHz.
  always #4 clk_i = ~clk_i;

  zone_plate_pattern_generator i_zone_plate_pattern_generator (.clk_i, .rst_b_i, .clear_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .frame_start_i, .line_start_i, .active_i,
    .comp0_o, .comp1_o, .comp2_o, .valid_o);

  zp_pixel_monitor i_zp_pixel_monitor (.clk_i, .rst_b_i, .active_i, .valid_i(valid_o),
    .comp0_i(comp0_o), .comp1_i(comp1_o), .comp2_i(comp2_o));

  // Output code for a full-scale unit level at the given base and amplitude.
  function automatic logic [9:0] code(input logic [9:0] base, input logic [10:0] amp);
    logic [63:0] v;
    v = 64'(base) + ((64'd1023 * amp * 64'd1282) >> 21);
    return (v > 64'h3fb) ? 10'h3fb : v[9:0];
  endfunction : code

  // Luma-only pixel with both chroma components at zero chroma.
  function automatic logic [29:0] yc(input logic [9:0] y);
    return {10'h200, 10'h200, y};
  endfunction : yc

  // Expected pixel for enable bits m[2:0] and the RGB structure bit m[3].
  function automatic logic [29:0] mix(input logic [3:0] m);
    logic [9:0] y;
    logic [9:0] c;
    logic [9:0] o;
    y = code(10'h040, 11'h578);
    c = m[3] ? y : code(10'h04a, 11'h578);
    o = m[3] ? 10'h040 : 10'h200;
    return {m[2] ? c : o, m[1] ? c : o, m[0] ? y : 10'h040};
  endfunction : mix

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One-cycle write strobe on the parameter port.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // One-cycle read strobe; the data are taken in the following cycle only.
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    rv = rdata_o;
    if (what != "") chk(what, exp, rv);
  endtask : rdc

  // Sets the control word, clears coefficients 1 to 9 and loads the phase offset.
  task automatic pat(input logic [31:0] ctrl, input logic [31:0] ph);
    wr(`ZP_REG_CTRL, ctrl);
    for (int k = 1; k < `ZP_NUM_COEF; k++) wr(`ZP_REG_COEF_BASE + 8'(4 * k), 32'h0);
    wr(`ZP_REG_COEF_BASE, ph);
  endtask : pat

  // One frame of nl lines with ns active samples each, then the pipeline drains.
  task automatic frame(input int nl, input int ns);
    i_zp_pixel_monitor.cap.delete();
    @(posedge clk_i) frame_start_i <= 1'b1;
    @(posedge clk_i) frame_start_i <= 1'b0;
    for (int l = 0; l < nl; l++) begin
      line_start_i <= 1'b1;
      @(posedge clk_i) line_start_i <= 1'b0;
      active_i <= 1'b1;
      repeat (ns) @(posedge clk_i);
      active_i <= 1'b0;
      @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
  endtask : frame

  // Compares captured sample i with the expected pixel.
  task automatic pix(input int i, input logic [29:0] exp);
    logic [29:0] got;
    got = (i < i_zp_pixel_monitor.cap.size()) ? i_zp_pixel_monitor.cap[i] : 30'hx;
    chk("pixel", {2'b00, exp}, {2'b00, got});
  endtask : pix

  // Checks n luma samples: a set mask bit means white, a clear one black.
  task automatic row(input logic [3:0] mask, input int n);
    for (int i = 0; i < n; i++) pix(i, yc(mask[i] ? code(10'h040, 11'h578) : 10'h040));
  endtask : row

  // Register defaults, an unmapped read and the idle outputs after reset.
  task automatic t_reset();
    @(posedge clk_i);
    #1;
    chk("comp0", 32'h040, 32'(comp0_o));
    chk("comp2", 32'h200, 32'(comp2_o));
    rdc(`ZP_REG_CTRL, 32'h01, "ctrl");
    rdc(`ZP_REG_AMP, 32'h578, "amp");
    for (int k = 0; k < `ZP_NUM_COEF; k++) begin
      rdc(`ZP_REG_COEF_BASE + 8'(4 * k), 32'h0, "coef");
    end
    rdc(8'h40, 32'h0, "unmapped");
    @(posedge clk_i);
    #1;
    chk("rdata idle", 32'h0, rdata_o);
  endtask : t_reset

  // Amplitude ceiling, saturation of the code and zero amplitude.
  task automatic t_amp();
    wr(`ZP_REG_AMP, 32'hfff);
    rdc(`ZP_REG_AMP, 32'h63c, "amp ceiling");
    pat(32'h01, 32'h4000_0000);
    frame(1, 1);
    pix(0, yc(code(10'h040, 11'h63c)));
    wr(`ZP_REG_AMP, 32'h0);
    frame(1, 1);
    pix(0, yc(10'h040));
    wr(`ZP_REG_AMP, 32'h578);
  endtask : t_amp

  // Every enable combination in both sample structures, then the phase offset sign.
  task automatic t_comp();
    for (int m = 0; m < 16; m++) begin
      wr(`ZP_REG_CTRL, {25'h0, m[3], 3'b000, m[2:0]});
      frame(1, 1);
      pix(0, mix(m[3:0]));
    end
    pat(32'h01, 32'hc000_0000);
    frame(1, 1);
    row(4'b0000, 1);
  endtask : t_comp

  // Each shape code, the spare one falling back to sine, at both peaks; square off-peak.
  task automatic t_shape();
    for (int s = 0; s < 4; s++) begin
      pat({26'h0, s[1:0], 4'h1}, 32'h4000_0000);
      frame(1, 1);
      row(4'b0001, 1);
      wr(`ZP_REG_COEF_BASE, 32'hc000_0000);
      frame(1, 1);
      row(4'b0000, 1);
    end
    pat(32'h21, 32'h2000_0000);
    frame(1, 1);
    row(4'b0001, 1);
  endtask : t_shape

  // Half-rate horizontal and vertical terms, the cross term alone, then a sweep whose DC
  // point falls between the last two samples of the line, so both sit at the mid-level code.
  task automatic t_space();
    pat(32'h01, 32'h4000_0000);
    wr(`ZP_REG_COEF_BASE + 8'(4 * `ZP_K_X), 32'h8000_0000);
    wr(`ZP_REG_COEF_BASE + 8'(4 * `ZP_K_Y), 32'h8000_0000);
    frame(2, 2);
    row(4'b1001, 4);
    pat(32'h01, 32'h4000_0000);
    wr(`ZP_REG_COEF_BASE + 8'(4 * `ZP_K_XY), 32'h8000_0000);
    frame(2, 2);
    row(4'b0111, 4);
    pat(32'h01, 32'h4000_0000);
    wr(`ZP_REG_COEF_BASE + 8'(4 * `ZP_K_X), 32'h8000_0000);
    wr(`ZP_REG_COEF_BASE + 8'(4 * `ZP_K_X2), 32'h4000_0000);
    frame(1, 4);
    row(4'b0001, 2);
    pix(2, yc(10'h1f6));
    pix(3, yc(10'h1f6));
  endtask : t_space

  // Whole-picture flashing, free-running time, time reset and the synchronous clear.
  task automatic t_time();
    pat(32'h01, 32'h4000_0000);
    wr(`ZP_REG_COEF_BASE + 8'(4 * `ZP_K_T), 32'h8000_0000);
    frame(1, 1);
    row(4'b0001, 1);
    frame(1, 1);
    row(4'b0000, 1);
    wr(`ZP_REG_COEF_BASE, 32'h8000_0000);
    wr(`ZP_REG_COEF_BASE + 8'(4 * `ZP_K_T), 32'hc000_0000);
    frame(1, 1);
    frame(1, 1);
    row(4'b0001, 1);
    rdc(`ZP_REG_TIME, 32'h23, "time count");
    wr(`ZP_REG_COEF_BASE + 8'(4 * `ZP_K_T), 32'h0);
    frame(1, 1);
    rdc(`ZP_REG_TIME, 32'h24, "time run");
    wr(`ZP_REG_CTRL, 32'h09);
    wr(`ZP_REG_COEF_BASE, 32'h4000_0000);
    wr(`ZP_REG_COEF_BASE + 8'(4 * `ZP_K_T), 32'h8000_0000);
    frame(1, 1);
    rdc(`ZP_REG_TIME, 32'h0, "time reset");
    frame(1, 1);
    row(4'b0001, 1);
    wr(`ZP_REG_CTRL, 32'h01);
    frame(1, 1);
    @(posedge clk_i) clear_i <= 1'b1;
    @(posedge clk_i) clear_i <= 1'b0;
    rdc(`ZP_REG_TIME, 32'h0, "time clear");
  endtask : t_time

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    chk("valid timing", 32'h0, i_zp_pixel_monitor.late_count);
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // Main sequence after a five-cycle reset.
  initial begin
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_amp();
    t_comp();
    t_shape();
    t_space();
    t_time();
    wrap_up();
  end

  // Cuts a hung run short.
  initial begin
    #400000;
    err_count++;
    wrap_up();
  end
endmodule : tb_zone_plate_pattern_generator
`default_nettype wire
